// ==== hct_defs.vh ====
// constants for the host-side command/acknowledge transaction engine
`ifndef HCT_DEFS_VH
`define HCT_DEFS_VH
`define HCT_CLK_HZ 10000000
`define HCT_CYC_PER_MS (`HCT_CLK_HZ / 1000)
`define HCT_MAX_PKT_BYTES 1024
`define HCT_BITS_PER_BYTE 10
`define HCT_LINK_BAUD 9600
// least time, rounded up to whole cycles
`define HCT_PKT_WIN_CYC ((64'd1024 * 64'd10 * 64'd10000000 + 64'd9599) / 64'd9600)
`define HCT_MARGIN_MS 10
`define HCT_MAX_RETRIES 2'h3
`define HCT_TAG_STEP 16'h0001
`define HCT_TAG_RESET 16'h0000
`define HCT_DEFAULT_PATH 8'h00
`define HCT_STATUS_OK 16'h0000
`define HCT_TX_CMD 1'b0
`define HCT_TX_EVT_REPLY 1'b1
`define HCT_EVT_NUM_LSB 0
`define HCT_EVT_NUM_MSB 11
`define HCT_EVT_RSV_LSB 12
`define HCT_EVT_RSV_MSB 13
`define HCT_EVT_NS_LSB 14
`define HCT_EVT_NS_MSB 15
`define HCT_NS_PROTOCOL 2'h0
`define HCT_NS_TECH 2'h1
`define HCT_NS_DEVICE 2'h2
`endif

// ==== hct_timer.v ====
// loadable down-counting timeout timer
`default_nettype none
module hct_timer #(
    parameter W = 32
) (
    input wire sys_clk,
    input wire reset,
    input wire ce,
    input wire load,
    input wire stop,
    input wire [W-1:0] load_val,
    output wire expired
);
    reg [W-1:0] cnt_q;
    reg run_q;
    always @(posedge sys_clk) begin
        if (reset) begin
            cnt_q <= {W{1'b0}};
            run_q <= 1'b0;
        end else if (ce) begin
            if (load) begin
                cnt_q <= load_val;
                run_q <= 1'b1;
            end else if (stop) begin
                run_q <= 1'b0;
            end else if (run_q && cnt_q != {W{1'b0}}) begin
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
    assign expired = run_q && (cnt_q == {W{1'b0}});
endmodule
`default_nettype wire

// ==== hct_engine.v ====
// host command/acknowledge transaction engine with event reply channel
`include "hct_defs.vh"
`default_nettype none
// Functional notes
// [R1] device executes each command and acknowledges with the same tag
// [R2] host issues one command at a time, waiting for acknowledge or timeout
// [R3] each new command cycle uses a new tag, incremented by one
// [R4] acknowledge timeout sums packet transfer time, device response time, margin
// [R5] device answers its response-time register read within 50 ms
// [R6] device should finish other register accesses within 300 ms
// [R7] device sends pending acknowledge with tag and temporary timeout in ms
// [R8] host uses pending timeout for this cycle only, then reverts
// [R9] device suspends heartbeat during pending command, restores afterwards
// [R10] device may send another pending acknowledge with longer timeout
// [R11] same-tag command while processing gets another pending acknowledge
// [R12] different-tag command while processing gets the busy status code
// [R13] event channel path number differs from the default path
// [R14] events carry tags; host replies with same tag; next event differs
// [R15] event source code: number bits 0-11, reserved 12-13, namespace 14-15
// [R16] namespace 0 protocol, 1 technology, 2 device specific
// [R17] bad CRC, timeout, short packet, bad header are link failures
// [R18] on CRC or length error flush until idle one packet time, then resend
// [R19] packet too short if incomplete within transfer window from first byte
// [R20] after failure host resends same command and tag up to 3 times
// [R21] device does not re-execute a resent tag, resends old result
// [R22] on corrupt acknowledge host may resend without waiting for timeout
// [R23] default control channel uses logical path number 0
module hct_engine #(
    parameter PKT_WIN_CYCLES = `HCT_PKT_WIN_CYC,
    parameter CYC_PER_MS = `HCT_CYC_PER_MS,
    parameter MARGIN_MS = `HCT_MARGIN_MS
) (
    input wire sys_clk,
    input wire reset,
    input wire ce,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire [15:0] cmd_opcode,
    input wire [31:0] cmd_data,
    input wire [15:0] max_response_time,
    output reg done_q,
    output reg done_fail_q,
    output reg done_busy_q,
    output reg [15:0] done_status_q,
    output reg [31:0] done_data_q,
    output reg tx_valid_q,
    input wire tx_ready,
    output reg tx_kind_q,
    output reg [7:0] tx_path_q,
    output reg [15:0] tx_tag_q,
    output reg [15:0] tx_opcode_q,
    output reg [31:0] tx_data_q,
    input wire rx_first_byte,
    input wire rx_valid,
    input wire [15:0] rx_tag,
    input wire rx_pending,
    input wire [15:0] rx_pend_ms,
    input wire [15:0] rx_status,
    input wire [31:0] rx_data,
    input wire rx_crc_err,
    input wire rx_len_err,
    input wire rx_hdr_err,
    input wire rx_evt_valid,
    input wire [15:0] rx_evt_tag,
    input wire [15:0] rx_evt_code,
    input wire line_active,
    input wire [7:0] msg_path,
    output reg msg_path_ok_q,
    input wire busy_status_code_in,
    output reg evt_valid_q,
    output reg [11:0] evt_number_q,
    output reg [1:0] evt_space_q,
    output reg evt_space_known_q
);
    localparam S_IDLE = 3'h0;
    localparam S_SEND = 3'h1;
    localparam S_WAIT = 3'h2;
    localparam S_FLUSH = 3'h3;
    localparam S_RESEND = 3'h4;

    // namespace field known to the protocol
    function ns_known;
        input [1:0] ns;
        begin
            ns_known = (ns == `HCT_NS_PROTOCOL) || (ns == `HCT_NS_TECH) || (ns == `HCT_NS_DEVICE); // R16
        end
    endfunction

    reg [2:0] st_q;
    reg [15:0] tag_q;
    reg [15:0] op_q;
    reg [31:0] data_q;
    reg [1:0] retry_q;
    reg pkt_open_q;
    reg evt_pend_q;
    reg [15:0] evt_tag_q;
    reg evt_seen_q;
    reg [15:0] last_evt_tag_q;
    reg line_m_q;
    reg line_s_q;

    wire [31:0] base_to = PKT_WIN_CYCLES[31:0] + {16'h0000, max_response_time} * CYC_PER_MS[31:0]
        + MARGIN_MS[31:0] * CYC_PER_MS[31:0]; // R4
    wire [31:0] pend_to = {16'h0000, rx_pend_ms} * CYC_PER_MS[31:0];
    wire ack_to;
    wire win_to;
    wire idle_to;

    wire rx_bad = rx_crc_err || rx_len_err || rx_hdr_err;
    wire ack_match = rx_valid && !rx_bad && (rx_tag == tag_q);
    wire short_pkt = pkt_open_q && win_to; // R19
    wire cmd_tx_go = (st_q == S_SEND || st_q == S_RESEND) && !evt_pend_q;
    wire evt_tx_go = evt_pend_q && !tx_valid_q;
    wire start_wait = tx_valid_q && tx_ready && (tx_kind_q == `HCT_TX_CMD);
    wire fail_ev = (st_q == S_WAIT) && (ack_to || short_pkt || rx_bad); // R17
    wire need_flush = rx_crc_err || rx_len_err || short_pkt; // R18

    assign cmd_ready = (st_q == S_IDLE); // R2

    // acknowledge timeout, reloaded by a pending acknowledge
    hct_timer #(.W(32)) u_ack_tmr (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .load(start_wait || (st_q == S_WAIT && ack_match && rx_pending)),
        .stop(st_q != S_WAIT),
        .load_val(start_wait ? base_to : pend_to), // R8
        .expired(ack_to)
    );

    // transfer window for an arriving packet
    hct_timer #(.W(32)) u_win_tmr (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .load(rx_first_byte),
        .stop(rx_valid || rx_bad),
        .load_val(PKT_WIN_CYCLES[31:0]),
        .expired(win_to)
    );

    // line quiet time during flush
    hct_timer #(.W(32)) u_idle_tmr (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .load(st_q != S_FLUSH || line_s_q),
        .stop(1'b0),
        .load_val(PKT_WIN_CYCLES[31:0]),
        .expired(idle_to)
    );

    always @(posedge sys_clk) begin
        if (reset) begin
            line_m_q <= 1'b0;
            line_s_q <= 1'b0;
            pkt_open_q <= 1'b0;
            msg_path_ok_q <= 1'b0;
        end else if (ce) begin
            line_m_q <= line_active;
            line_s_q <= line_m_q;
            if (rx_first_byte)
                pkt_open_q <= 1'b1;
            else if (rx_valid || rx_bad || win_to)
                pkt_open_q <= 1'b0;
            msg_path_ok_q <= (msg_path != `HCT_DEFAULT_PATH); // R13
        end
    end

    // event intake and reply
    always @(posedge sys_clk) begin
        if (reset) begin
            evt_pend_q <= 1'b0;
            evt_tag_q <= `HCT_TAG_RESET;
            evt_seen_q <= 1'b0;
            last_evt_tag_q <= `HCT_TAG_RESET;
            evt_valid_q <= 1'b0;
            evt_number_q <= 12'h000;
            evt_space_q <= 2'h0;
            evt_space_known_q <= 1'b0;
        end else if (ce) begin
            evt_valid_q <= 1'b0;
            if (rx_evt_valid && !rx_bad) begin
                evt_pend_q <= 1'b1;
                evt_tag_q <= rx_evt_tag; // R14
                if (!evt_seen_q || rx_evt_tag != last_evt_tag_q) begin
                    evt_valid_q <= 1'b1;
                    evt_number_q <= rx_evt_code[`HCT_EVT_NUM_MSB:`HCT_EVT_NUM_LSB]; // R15
                    evt_space_q <= rx_evt_code[`HCT_EVT_NS_MSB:`HCT_EVT_NS_LSB];
                    evt_space_known_q <= ns_known(rx_evt_code[`HCT_EVT_NS_MSB:`HCT_EVT_NS_LSB]) &&
                        (rx_evt_code[`HCT_EVT_RSV_MSB:`HCT_EVT_RSV_LSB] == 2'h0);
                end
                evt_seen_q <= 1'b1;
                last_evt_tag_q <= rx_evt_tag;
            end else if (tx_valid_q && tx_ready && tx_kind_q == `HCT_TX_EVT_REPLY) begin
                evt_pend_q <= 1'b0;
            end
        end
    end

    // command cycle
    always @(posedge sys_clk) begin
        if (reset) begin
            st_q <= S_IDLE;
            tag_q <= `HCT_TAG_RESET;
            op_q <= 16'h0000;
            data_q <= 32'h00000000;
            retry_q <= 2'h0;
            tx_valid_q <= 1'b0;
            tx_kind_q <= `HCT_TX_CMD;
            tx_path_q <= `HCT_DEFAULT_PATH;
            tx_tag_q <= `HCT_TAG_RESET;
            tx_opcode_q <= 16'h0000;
            tx_data_q <= 32'h00000000;
            done_q <= 1'b0;
            done_fail_q <= 1'b0;
            done_busy_q <= 1'b0;
            done_status_q <= `HCT_STATUS_OK;
            done_data_q <= 32'h00000000;
        end else if (ce) begin
            done_q <= 1'b0;
            if (tx_valid_q && tx_ready)
                tx_valid_q <= 1'b0;
            if (!tx_valid_q) begin
                if (evt_tx_go) begin
                    tx_valid_q <= 1'b1;
                    tx_kind_q <= `HCT_TX_EVT_REPLY;
                    tx_path_q <= msg_path; // R13
                    tx_tag_q <= evt_tag_q; // R14
                    tx_opcode_q <= 16'h0000;
                    tx_data_q <= 32'h00000000;
                end else if (cmd_tx_go) begin
                    tx_valid_q <= 1'b1;
                    tx_kind_q <= `HCT_TX_CMD;
                    tx_path_q <= `HCT_DEFAULT_PATH; // R23
                    tx_tag_q <= tag_q; // R20
                    tx_opcode_q <= op_q;
                    tx_data_q <= data_q;
                end
            end
            case (st_q)
                S_IDLE: begin
                    if (cmd_valid) begin
                        op_q <= cmd_opcode;
                        data_q <= cmd_data;
                        retry_q <= 2'h0;
                        st_q <= S_SEND;
                    end
                end
                S_SEND, S_RESEND: begin
                    if (cmd_tx_go && !tx_valid_q)
                        st_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (ack_match && !rx_pending) begin
                        done_q <= 1'b1; // R1
                        done_fail_q <= 1'b0;
                        done_busy_q <= busy_status_code_in; // R12
                        done_status_q <= rx_status;
                        done_data_q <= rx_data;
                        tag_q <= tag_q + `HCT_TAG_STEP; // R3
                        st_q <= S_IDLE;
                    end else if (fail_ev) begin
                        if (retry_q == `HCT_MAX_RETRIES) begin
                            done_q <= 1'b1;
                            done_fail_q <= 1'b1;
                            done_busy_q <= 1'b0;
                            done_status_q <= `HCT_STATUS_OK;
                            done_data_q <= 32'h00000000;
                            retry_q <= 2'h0;
                            tag_q <= tag_q + `HCT_TAG_STEP;
                            st_q <= need_flush ? S_FLUSH : S_IDLE;
                        end else begin
                            retry_q <= retry_q + 2'h1; // R20
                            st_q <= need_flush ? S_FLUSH : S_RESEND; // R22
                        end
                    end
                end
                S_FLUSH: begin
                    if (idle_to) // R18
                        st_q <= (retry_q == 2'h0) ? S_IDLE : S_RESEND;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== hct_engine_chk.sv ====
// assertions on the host transaction engine ports
`default_nettype none
module hct_engine_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic done_q,
    input wire logic tx_valid_q,
    input wire logic tx_ready,
    input wire logic tx_kind_q,
    input wire logic [7:0] tx_path_q,
    input wire logic [15:0] tx_tag_q,
    input wire logic [7:0] msg_path,
    input wire logic rx_evt_valid,
    input wire logic evt_valid_q,
    input wire logic [1:0] evt_space_q,
    input wire logic evt_space_known_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    send_after_take_a: assert property (cmd_valid && cmd_ready && ce |-> ##[2:3] tx_valid_q)
        else $error("command not sent after take");
    tx_stands_a: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_tag_q))
        else $error("transmit request dropped early");
    one_at_time_a: assert property (tx_valid_q && !tx_kind_q |-> !cmd_ready)
        else $error("ready while sending");
    cmd_path_a: assert property (tx_valid_q && !tx_kind_q |-> tx_path_q == 8'h00)
        else $error("command not on default path");
    evt_path_a: assert property (tx_valid_q && tx_kind_q |-> tx_path_q == msg_path)
        else $error("event reply on wrong path");
    evt_reply_a: assert property (rx_evt_valid && ce |-> ##[1:20] (tx_valid_q && tx_kind_q))
        else $error("no event reply");
    done_pulse_a: assert property (done_q |=> !done_q)
        else $error("done longer than one cycle");
    space_known_a: assert property (evt_valid_q |-> evt_space_known_q == (evt_space_q != 2'h3))
        else $error("namespace flag wrong");
    cover property (done_q);
    cover property (tx_valid_q && tx_kind_q);
    cover property (evt_valid_q && !evt_space_known_q);
endmodule
bind hct_engine hct_engine_chk chk (.*);
`default_nettype wire

// ==== hct_dev_model.sv ====
// behavioural device answering the host engine
`default_nettype none
module hct_dev_model (
    input wire logic sys_clk,
    input wire logic tx_valid_q,
    input wire logic tx_kind_q,
    input wire logic [15:0] tx_tag_q,
    input wire logic [31:0] tx_data_q,
    input wire logic [1:0] mode,
    input wire logic [2:0] err_cnt,
    output logic tx_ready,
    output logic rx_first_byte,
    output logic rx_valid,
    output logic rx_pending,
    output logic rx_crc_err,
    output logic busy_status_code_in,
    output logic line_active,
    output logic [15:0] rx_tag,
    output logic [15:0] rx_pend_ms,
    output logic [15:0] rx_status,
    output logic [31:0] rx_data,
    output logic [15:0] reply_tag,
    output int n_cmd,
    output int n_exec
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] t, done_tag, err_tag;
    logic [31:0] res;
    int errs;
    task automatic ack(input logic pend, input logic bad);
        line_active <= 1'b1;
        rx_first_byte <= 1'b1;
        @(posedge sys_clk);
        rx_first_byte <= 1'b0;
        rx_valid <= !bad;
        rx_crc_err <= bad;
        rx_pending <= pend;
        rx_tag <= t;
        rx_data <= res;
        busy_status_code_in <= (mode == 2'd2);
        rx_status <= (mode == 2'd2) ? 16'h0004 : 16'h0000;
        @(posedge sys_clk);
        {rx_valid, rx_crc_err, rx_pending, line_active} <= 4'h0;
        rx_tag <= ~t;
        rx_data <= ~res;
    endtask
    initial begin
        {tx_ready, rx_first_byte, rx_valid, rx_pending, rx_crc_err, busy_status_code_in, line_active} = 7'h00;
        {rx_tag, rx_status, rx_data, reply_tag, res} = '0;
        rx_pend_ms = 16'd60;
        {done_tag, err_tag} = 32'hffff_ffff;
        {n_cmd, n_exec, errs} = '0;
        forever begin
            @(posedge sys_clk) #1;
            if (tx_valid_q === 1'b1) begin
                tx_ready <= 1'b1;
                t = tx_tag_q;
                @(posedge sys_clk) #1 tx_ready <= 1'b0;
                if (tx_kind_q)
                    reply_tag <= t;
                else begin
                    n_cmd++;
                    if (t != done_tag && mode != 2'd2) begin
                        done_tag = t;
                        res = tx_data_q + 32'h1;
                        n_exec++;
                    end
                    repeat (3) @(posedge sys_clk);
                    if (mode == 2'd1) begin
                        rx_pend_ms <= 16'd60;
                        ack(1'b1, 1'b0);
                        repeat (400) @(posedge sys_clk); // heartbeat hold is not visible to the host
                        rx_pend_ms <= 16'd90;
                        ack(1'b1, 1'b0);
                        repeat (500) @(posedge sys_clk);
                    end
                    if (t != err_tag) begin
                        err_tag = t;
                        errs = 0;
                    end
                    if (errs < err_cnt) begin
                        errs++;
                        if (mode != 2'd3) // mode 3 loses the acknowledge
                            ack(1'b0, 1'b1);
                    end else
                        ack(1'b0, 1'b0);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== hct_engine_tb.sv ====
// self-checking bench for the host transaction engine
`default_nettype none
module hct_engine_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] d; logic [1:0] m; logic [2:0] e; logic fail; logic busy; int cmds; int ex;} hct_row_t;
    hct_row_t rows [7] = '{'{32'h0000_1234, 2'd0, 3'd0, 1'b0, 1'b0, 1, 1}, '{32'hffff_ffff, 2'd0, 3'd0, 1'b0, 1'b0, 1, 1},
        '{32'h0000_0042, 2'd1, 3'd0, 1'b0, 1'b0, 1, 1}, '{32'h0000_0007, 2'd2, 3'd0, 1'b0, 1'b1, 1, 0},
        '{32'h0000_0100, 2'd0, 3'd1, 1'b0, 1'b0, 2, 1}, '{32'h0000_0200, 2'd0, 3'd7, 1'b1, 1'b0, 4, 1},
        '{32'h0000_0300, 2'd3, 3'd1, 1'b0, 1'b0, 2, 1}};
    logic sys_clk, reset, ce, cmd_valid, cmd_ready, done_q, done_fail_q, done_busy_q, tx_valid_q, tx_ready, tx_kind_q;
    logic rx_first_byte, rx_valid, rx_pending, rx_crc_err, rx_evt_valid, line_active, msg_path_ok_q;
    logic busy_status_code_in, evt_valid_q, evt_space_known_q;
    logic [1:0] mode, evt_space_q;
    logic [2:0] err_cnt;
    logic [7:0] tx_path_q, msg_path;
    logic [11:0] evt_number_q;
    logic [15:0] done_status_q, tx_tag_q, tx_opcode_q, rx_tag, rx_pend_ms, rx_status, rx_evt_tag, rx_evt_code, reply_tag, tg;
    logic [15:0] cmd_opcode;
    logic [31:0] cmd_data, done_data_q, tx_data_q, rx_data;
    int n_cmd, n_exec, n_mismatch, samples_checked, n_evt, c0, x0, e0;
    hct_engine #(.PKT_WIN_CYCLES(200), .CYC_PER_MS(10), .MARGIN_MS(10)) dut (.*, .max_response_time(16'd2),
        .rx_len_err(1'b0), .rx_hdr_err(1'b0));
    hct_dev_model dev (.*);
    task automatic chk(input logic ok, input string what);
        samples_checked++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wait_idle;
        repeat (1000) begin
            @(posedge sys_clk) #1;
            if (cmd_ready === 1'b1) break;
        end
    endtask
    task automatic wait_done;
        repeat (3000) begin
            @(posedge sys_clk) #1;
            if (done_q === 1'b1) break;
        end
    endtask
    task automatic issue(input logic [31:0] d, input logic [15:0] op);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_data <= d;
        cmd_opcode <= op;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        wait_done;
    endtask
    always @(posedge sys_clk) if (evt_valid_q === 1'b1) n_evt++;
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        results;
    end
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        {cmd_valid, rx_evt_valid, mode, err_cnt} = '0;
        {cmd_data, cmd_opcode, rx_evt_tag, rx_evt_code} = '0;
        {n_mismatch, samples_checked, n_evt, msg_path} = {96'h0, 8'h05};
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        #1 chk(cmd_ready === 1'b1 && tx_valid_q === 1'b0 && done_q === 1'b0, "reset state");
        foreach (rows[i]) begin
            wait_idle;
            {mode, err_cnt, c0, x0} = {rows[i].m, rows[i].e, n_cmd, n_exec};
            issue(rows[i].d, 16'h0010 + 16'(i));
            chk(done_q === 1'b1 && done_busy_q === rows[i].busy, "done or busy flag");
            chk(done_status_q === (rows[i].busy ? 16'h0004 : 16'h0000), "status word");
            chk(tx_opcode_q === 16'h0010 + 16'(i), "sent opcode");
            chk(done_fail_q === rows[i].fail, "fail flag");
            if (!rows[i].fail && !rows[i].busy) chk(done_data_q === rows[i].d + 32'h1, "result data");
            chk(n_cmd - c0 == rows[i].cmds && n_exec - x0 == rows[i].ex, "attempt count");
            $display("row %0d finished", i);
        end
        wait_idle;
        chk(msg_path_ok_q === 1'b1, "path flag");
        for (int k = 0; k < 5; k++) begin
            {e0, tg} = {n_evt, (k == 4) ? 16'h0013 : 16'h0010 + 16'(k)};
            @(posedge sys_clk);
            rx_evt_valid <= 1'b1;
            rx_evt_tag <= tg;
            rx_evt_code <= {2'(k), 2'b00, 12'h0a0 + 12'(k)};
            @(posedge sys_clk);
            rx_evt_valid <= 1'b0;
            repeat (20) @(posedge sys_clk);
            #1 chk(reply_tag === tg && n_evt - e0 == (k < 4), "event reply or flag");
            if (k < 4) chk(evt_number_q === 12'h0a0 + 12'(k) && evt_space_q === 2'(k), "event fields");
            if (k < 4) chk(evt_space_known_q === (k < 3), "namespace known flag");
            $display("event %0d finished", k);
        end
        wait_idle;
        {mode, err_cnt, c0} = {2'd0, 3'd0, n_cmd};
        @(posedge sys_clk);
        ce <= 1'b0;
        cmd_valid <= 1'b1;
        cmd_data <= 32'h0000_0500;
        repeat (4) @(posedge sys_clk);
        #1 chk(cmd_ready === 1'b1 && tx_valid_q === 1'b0 && n_cmd == c0, "frozen by clock enable");
        @(posedge sys_clk);
        ce <= 1'b1;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        wait_done;
        chk(done_q === 1'b1 && done_data_q === 32'h0000_0501 && n_cmd - c0 == 1, "command after freeze");
        $display("freeze test finished");
        wait_idle;
        @(posedge sys_clk);
        reset <= 1'b1;
        msg_path <= 8'h00;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        cmd_valid <= 1'b1;
        cmd_data <= 32'h0000_0600;
        #1 chk(cmd_ready === 1'b1 && tx_tag_q === 16'h0000 && done_data_q === 32'h0, "mid-run reset");
        chk(evt_number_q === 12'h000 && msg_path_ok_q === 1'b0, "mid-run reset outputs");
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        wait_done;
        chk(done_data_q === 32'h0000_0601 && tx_tag_q === 16'h0000, "first command after reset");
        chk(msg_path_ok_q === 1'b0, "default path refused for events");
        $display("reset test finished");
        results;
    end
endmodule
`default_nettype wire
